// *** verilog/acs_pkg.sv ***
// Purpose: Shared constants and types for the ADC conversion sequencer.
// Assumes: 40 MHz clock; 8-bit register port from the serial register slave.
// Notes:   Control bit positions are fixed here and used by the sequencer.
package acs_pkg;

    localparam logic [7:0] ADDR_RESULT_HIGH = 8'hE5;
    localparam logic [7:0] ADDR_RESULT_LOW  = 8'hE6;
    localparam logic [7:0] ADDR_STATUS      = 8'hE7;
    localparam logic [7:0] ADDR_CONTROL     = 8'hE8;
    localparam logic [7:0] ADDR_AUX         = 8'hE9;

    localparam int CTRL_GO_BIT       = 7;
    localparam int CTRL_ONE_SHOT_BIT = 6;
    localparam int CTRL_SCAN_BIT     = 5;
    localparam int CTRL_BUF_BIT      = 4;
    localparam int STAT_DONE_BIT     = 7;
    localparam int STAT_BUSY_BIT     = 0;
    localparam int AUX_MASK_BIT      = 7;
    localparam int AUX_ENABLE_BIT    = 6;

    localparam int CHANNELS = 8;
    localparam int CHAN_W   = 3;
    localparam int RESULT_W = 14;
    localparam int COUNT_W  = 16;

    localparam logic [CHAN_W-1:0]   FIRST_CHANNEL = 3'h0;
    localparam logic [CHAN_W-1:0]   LAST_CHANNEL  = 3'h7;
    localparam logic [7:0]          CONTROL_RESET = 8'h00;
    localparam logic [7:0]          AUX_RESET     = 8'h00;
    localparam logic [RESULT_W-1:0] RESULT_RESET  = 14'h0000;

    localparam int CLOCK_PERIOD_NS = 25;
    localparam int CONV_TIME_NS    = 2000;
    localparam int CONV_CYCLES     = (CONV_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    typedef enum logic {ACS_IDLE, ACS_CONVERT} acs_state_t;

endpackage

// *** verilog/acs_result_bank.sv ***
// Purpose: Eight per-channel result stores with an eight-to-one read selector.
// Assumes: Store strobe and data come from the sequencer on the same clock.
// Notes:   Read side is combinational; the caller registers what leaves the block.
`timescale 1ns/1ps
module acs_result_bank
    import acs_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                rstn,
    input  wire logic                store_en,
    input  wire logic [CHAN_W-1:0]   store_channel,
    input  wire logic [RESULT_W-1:0] store_data,
    input  wire logic [CHAN_W-1:0]   read_channel,
    output logic      [RESULT_W-1:0] read_data
);

    logic [RESULT_W-1:0] store [CHANNELS];

    ////////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_store
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    store[g] <= RESULT_RESET;
                end else if (store_en && store_channel == CHAN_W'(g)) begin
                    store[g] <= store_data;
                end
            end
        end
    endgenerate

    assign read_data = store[read_channel];

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    property p_store_kept;
        store_en ##1 (read_channel == $past(store_channel)) |-> read_data == $past(store_data);
    endproperty
    a_store_kept: assert property (p_store_kept) else $error("stored result not exposed");

    c_store_last: cover property (store_en && store_channel == LAST_CHANNEL);

endmodule

// *** verilog/acs_sequencer.sv ***
// Purpose: Conversion sequencer and host registers for the monitoring converter.
// Assumes: Register port driven by the serial register slave on the same clock.
// Notes:   Converter data is sampled a fixed latency after each start pulse.
`timescale 1ns/1ps
// What this block does
// - One shared converter; an input selector routes one of eight inputs per conversion.
// - Each channel keeps its own result; an eight-to-one selector exposes one.
// - Single-shot and scan modes exist; an enable bit in the aux register gates converter operation.
// - Three-bit fields pick channel to convert and channel to expose.
// - Writing go as one starts a conversion of the selected channel.
// - Completion sets done flag, drives interrupt low, clears go by itself.
// - Result bits 13..6 read at 0xE5, bits 5..0 at 0xE6.
// - Done and interrupt hold until the low result byte at 0xE6 is read; that read releases interrupt.
// - In scan mode go converts every channel in turn into its store.
// - A mask bit keeps completion from driving the interrupt low.
module acs_sequencer
    import acs_pkg::*;
#(
    parameter int CONV_LATENCY = CONV_CYCLES
)
(
    input  wire logic                clock,
    input  wire logic                rstn,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_write,
    input  wire logic                reg_read,
    output logic      [7:0]          reg_rdata,
    output logic                     interrupt_request_n,
    output logic                     converter_enable,
    output logic      [CHAN_W-1:0]   converter_channel,
    output logic                     converter_start,
    input  wire logic [RESULT_W-1:0] converter_data
);

    acs_state_t          state;
    logic                one_shot;
    logic                all_channel_scan;
    logic                input_buffer_enable;
    logic [CHAN_W-1:0]   convert_channel_select;
    logic [CHAN_W-1:0]   result_channel_select;
    logic                ready_mask;
    logic                converter_on;
    logic                done;
    logic                scan_run;
    logic [COUNT_W-1:0]  count;
    logic [RESULT_W-1:0] exposed;

    ////////////////////////////////////////////////////////////////////////////
    wire busy        = (state == ACS_CONVERT);
    wire ctrl_write  = reg_write && reg_addr == ADDR_CONTROL;
    wire aux_write   = reg_write && reg_addr == ADDR_AUX;
    wire ctrl_accept = ctrl_write && !busy;
    wire go_accept   = ctrl_accept && reg_wdata[CTRL_GO_BIT] && converter_on;
    wire sample      = busy && count == '0;
    wire last_step   = !scan_run || converter_channel == LAST_CHANNEL;
    wire complete    = sample && last_step;
    wire step_next   = sample && !last_step;
    wire result_read = reg_read && reg_addr == ADDR_RESULT_LOW;
    wire next_done   = complete || (done && !result_read);

    wire [COUNT_W-1:0] reload = COUNT_W'(CONV_LATENCY - 1);
    wire [7:0] control_view = {busy, one_shot, all_channel_scan, input_buffer_enable,
                               1'b0, convert_channel_select};
    wire [7:0] aux_view     = {ready_mask, converter_on, 3'h0, result_channel_select};
    wire [7:0] status_view  = {done, 6'h00, busy};
    wire [7:0] read_value   = (reg_addr == ADDR_RESULT_HIGH) ? exposed[13:6] :
                              (reg_addr == ADDR_RESULT_LOW)  ? {2'h0, exposed[5:0]} :
                              (reg_addr == ADDR_STATUS)      ? status_view :
                              (reg_addr == ADDR_CONTROL)     ? control_view :
                              (reg_addr == ADDR_AUX)         ? aux_view : 8'h00;

    assign interrupt_request_n = !(done && !ready_mask);
    assign converter_enable    = input_buffer_enable && converter_on;

    ////////////////////////////////////////////////////////////////////////////
    // Control settings are frozen during a conversion so the input selector cannot move mid-sample.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            one_shot               <= CONTROL_RESET[CTRL_ONE_SHOT_BIT];
            all_channel_scan       <= CONTROL_RESET[CTRL_SCAN_BIT];
            input_buffer_enable    <= CONTROL_RESET[CTRL_BUF_BIT];
            convert_channel_select <= CONTROL_RESET[CHAN_W-1:0];
        end else if (ctrl_accept) begin
            one_shot               <= reg_wdata[CTRL_ONE_SHOT_BIT];
            all_channel_scan       <= reg_wdata[CTRL_SCAN_BIT];
            input_buffer_enable    <= reg_wdata[CTRL_BUF_BIT];
            convert_channel_select <= reg_wdata[CHAN_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ready_mask            <= AUX_RESET[AUX_MASK_BIT];
            converter_on          <= AUX_RESET[AUX_ENABLE_BIT];
            result_channel_select <= AUX_RESET[CHAN_W-1:0];
        end else if (aux_write) begin
            ready_mask            <= reg_wdata[AUX_MASK_BIT];
            converter_on          <= reg_wdata[AUX_ENABLE_BIT];
            result_channel_select <= reg_wdata[CHAN_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The go bit reads back as the busy state, so it clears itself on completion.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state             <= ACS_IDLE;
            scan_run          <= 1'b0;
            count             <= '0;
            converter_channel <= FIRST_CHANNEL;
            converter_start   <= 1'b0;
        end else begin
            converter_start <= go_accept || step_next;
            unique case (state)
                ACS_IDLE: begin
                    if (go_accept) begin
                        state             <= ACS_CONVERT;
                        scan_run          <= reg_wdata[CTRL_SCAN_BIT];
                        count             <= reload;
                        converter_channel <= reg_wdata[CTRL_SCAN_BIT] ? FIRST_CHANNEL
                                                                      : reg_wdata[CHAN_W-1:0];
                    end
                end
                ACS_CONVERT: begin
                    if (complete) begin
                        state <= ACS_IDLE;
                    end else if (step_next) begin
                        count             <= reload;
                        converter_channel <= converter_channel + 3'h1;
                    end else begin
                        count <= count - 16'h0001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            done      <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            done <= next_done;
            if (reg_read) begin
                reg_rdata <= read_value;
            end
        end
    end

    acs_result_bank u_bank (
        .clock         (clock),
        .rstn          (rstn),
        .store_en      (sample),
        .store_channel (converter_channel),
        .store_data    (converter_data),
        .read_channel  (result_channel_select),
        .read_data     (exposed)
    );

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    logic [COUNT_W-1:0] since_start;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            since_start <= '0;
        end else if (converter_start) begin
            since_start <= 16'h0001;
        end else begin
            since_start <= since_start + 16'h0001;
        end
    end

    property p_start;
        go_accept |=> converter_start && busy;
    endproperty
    a_start: assert property (p_start) else $error("go write did not start");

    property p_complete_irq;
        complete && !ready_mask |=> !interrupt_request_n && done && !control_view[CTRL_GO_BIT];
    endproperty
    a_complete_irq: assert property (p_complete_irq) else $error("completion not flagged");

    property p_hold;
        done && !result_read |=> done;
    endproperty
    a_hold: assert property (p_hold) else $error("done dropped before read");

    property p_release;
        result_read && !complete && !busy |=> interrupt_request_n;
    endproperty
    a_release: assert property (p_release) else $error("read did not release");

    property p_masked;
        ready_mask |-> interrupt_request_n;
    endproperty
    a_masked: assert property (p_masked) else $error("masked interrupt asserted");

    property p_frozen;
        busy && ctrl_write && !sample |=> $stable(converter_channel) && busy;
    endproperty
    a_frozen: assert property (p_frozen) else $error("write disturbed busy state");

    property p_latency;
        sample |-> since_start == COUNT_W'(CONV_LATENCY - 1);
    endproperty
    a_latency: assert property (p_latency) else $error("wrong conversion latency");

    property p_disabled;
        ctrl_write && !busy && !converter_on |=> !busy && !converter_start;
    endproperty
    a_disabled: assert property (p_disabled) else $error("started while disabled");

    property p_scan_step;
        step_next |=> converter_channel == $past(converter_channel) + 3'h1 && converter_start;
    endproperty
    a_scan_step: assert property (p_scan_step) else $error("scan did not advance");

    property p_high_byte;
        reg_read && reg_addr == ADDR_RESULT_HIGH |=> reg_rdata == $past(exposed[13:6]);
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("high result byte wrong");

    c_single: cover property (go_accept && !reg_wdata[CTRL_SCAN_BIT]);
    c_scan_done: cover property (complete && scan_run);
    c_read_release: cover property (done && result_read);

endmodule

// *** verification/acs_converter_model.sv ***
// Purpose: Behavioural model of the shared converter behind the input selector.
// Assumes: Start pulse, channel and data all live on the sequencer clock.
// Notes:   Data holds LAT+1 cycles after a start, then shows its inverse.
`timescale 1ns/1ps
module acs_converter_model
    import acs_pkg::*;
#(
    parameter int LAT = 4
)
(
    input  wire logic                clock,
    input  wire logic                rstn,
    input  wire logic [CHAN_W-1:0]   converter_channel,
    input  wire logic                converter_start,
    input  wire logic [RESULT_W-1:0] base,
    output logic      [RESULT_W-1:0] converter_data,
    output logic      [CHAN_W-1:0]   last_channel,
    output logic      [7:0]          start_count
);
    logic [RESULT_W-1:0] held;
    int                  left;
    ////////////////////////////////////////////////////////////////////////////
    // Stale data is inverted so a late sample cannot pass by luck.
    assign converter_data = (left > 0) ? held : ~held;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            held         <= RESULT_RESET;
            left         <= 0;
            last_channel <= FIRST_CHANNEL;
            start_count  <= 8'h00;
        end else if (converter_start) begin
            held         <= base + RESULT_W'(converter_channel) * 14'h0123;
            left         <= LAT + 1;
            last_channel <= converter_channel;
            start_count  <= start_count + 8'h01;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end
endmodule

// *** verification/acs_sequencer_tb.sv ***
// Purpose: Self-checking bench for the conversion sequencer.
// Assumes: Register strobes are single-cycle pulses driven at the falling edge.
// Notes:   A short latency keeps the run brief; expectations follow from it.
`timescale 1ns/1ps
module acs_sequencer_tb;
    import acs_pkg::*;
    localparam int LAT = 4;
    logic                clock;
    logic                rstn;
    logic [7:0]          reg_addr;
    logic [7:0]          reg_wdata;
    logic                reg_write;
    logic                reg_read;
    logic [7:0]          reg_rdata;
    logic                interrupt_request_n;
    logic                converter_enable;
    logic [CHAN_W-1:0]   converter_channel;
    logic                converter_start;
    logic [RESULT_W-1:0] converter_data;
    logic [RESULT_W-1:0] base;
    logic [CHAN_W-1:0]   last_channel;
    logic [7:0]          start_count;
    logic [31:0]         seed_word;
    logic [RESULT_W-1:0] e;
    logic [7:0]          s0;
    int                  fail_count;
    int                  cmp_count;
    ////////////////////////////////////////////////////////////////////////////
    acs_sequencer #(.CONV_LATENCY(LAT)) acs_sequencer_i (
        .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .interrupt_request_n(interrupt_request_n), .converter_enable(converter_enable),
        .converter_channel(converter_channel), .converter_start(converter_start),
        .converter_data(converter_data));
    acs_converter_model #(.LAT(LAT)) acs_converter_model_i (
        .clock(clock), .rstn(rstn), .converter_channel(converter_channel),
        .converter_start(converter_start), .base(base), .converter_data(converter_data),
        .last_channel(last_channel), .start_count(start_count));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [RESULT_W-1:0] expect_result(input logic [RESULT_W-1:0] b,
                                                          input logic [2:0] c);
        return b + RESULT_W'(c) * 14'h0123;
    endfunction
    task automatic close_out();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clock);
        reg_write = 1'b0;
    endtask
    task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clock);
        reg_read = 1'b0;
        @(negedge clock);
        chk8(reg_rdata, exp);
    endtask
    // A single conversion; optionally poked while busy or run with the mask set.
    task automatic convert_one(input logic [2:0] c, input logic poke, input logic mask,
                               input logic os);
        int k;
        @(negedge clock);
        base = RESULT_W'($urandom);
        e = expect_result(base, c);
        s0 = start_count;
        reg_wr(ADDR_AUX, {mask, 1'b1, 3'b000, c});
        reg_wr(ADDR_CONTROL, {1'b1, os, 3'b010, c});
        chk1(converter_enable, 1'b1);
        if (poke) begin
            reg_wr(ADDR_CONTROL, {5'b11110, ~c});
        end
        k = 0;
        while (interrupt_request_n !== 1'b0 && k < LAT * 4 + 20) begin
            @(negedge clock);
            k++;
        end
        chk1(interrupt_request_n, mask);
        chk8(start_count - s0, 8'h01);
        chk8({5'h00, last_channel}, {5'h00, c});
        check_reg(ADDR_STATUS, 8'h80);
        check_reg(ADDR_CONTROL, {1'b0, os, 3'b010, c});
        check_reg(ADDR_RESULT_HIGH, e[13:6]);
        chk1(interrupt_request_n, mask);
        check_reg(ADDR_RESULT_LOW, {2'b00, e[5:0]});
        chk1(interrupt_request_n, 1'b1);
        check_reg(ADDR_STATUS, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        base = RESULT_RESET;
        fail_count = 0;
        cmp_count = 0;
        seed_word = $urandom(32'hA823);
        repeat (12) @(posedge clock);
        @(negedge clock);
        rstn = 1'b1;
        chk1(interrupt_request_n, 1'b1);
        chk1(converter_enable, 1'b0);
        check_reg(ADDR_CONTROL, CONTROL_RESET);
        check_reg(ADDR_AUX, AUX_RESET);
        reg_wr(ADDR_STATUS, 8'hFF);
        check_reg(ADDR_STATUS, 8'h00);
        check_reg(8'hE4, 8'h00);
        reg_wr(ADDR_CONTROL, 8'hD3);
        repeat (LAT * 3) @(negedge clock);
        chk8(start_count, 8'h00);
        check_reg(ADDR_CONTROL, 8'h53);
        convert_one(3'h0, 1'b0, 1'b0, 1'b1);
        convert_one(3'h7, 1'b1, 1'b0, 1'b1);
        convert_one(3'h3, 1'b0, 1'b1, 1'b1);
        for (int i = 0; i < 10; i++) begin
            convert_one(3'($urandom), 1'($urandom), $urandom % 4 == 0, 1'($urandom));
        end
        // Scan: every channel lands in its own store.
        base = RESULT_W'($urandom);
        s0 = start_count;
        reg_wr(ADDR_AUX, 8'h40);
        reg_wr(ADDR_CONTROL, 8'hF0);
        for (int k = 0; k < 16 * (LAT + 4) + 40 && interrupt_request_n !== 1'b0; k++) begin
            @(negedge clock);
        end
        chk1(interrupt_request_n, 1'b0);
        chk8(start_count - s0, 8'h08);
        reg_wr(ADDR_CONTROL, 8'h50);
        for (int i = 0; i < CHANNELS; i++) begin
            e = expect_result(base, 3'(i));
            reg_wr(ADDR_CONTROL, 8'h50 | 8'(i));
            reg_wr(ADDR_AUX, 8'h40 | 8'(i));
            check_reg(ADDR_RESULT_HIGH, e[13:6]);
            check_reg(ADDR_RESULT_LOW, {2'b00, e[5:0]});
        end
        close_out();
    end
    initial begin
        #1000000;
        fail_count++;
        close_out();
    end
endmodule
